// File: logic/timer_pkg.sv
// constants, field layouts and mode encodings of the timer channel
// assumes a single pclk domain and an apb master outside
// Contract
// - clock mode joins halves, first load 0x1
// - 32.768 khz pin input divided to 1 hz
// - count equal match sets clock-match raw flag
// - clock counter rolls over to zero, continues
// - unmasked match sets masked flag; clear bit clears
// - clock mode ignores debug stall when enabled
// - predivider state readable through predivide register
// - edge count uses prescale-high, timer-low counter
// - capture bit clear selects edge count, event field
// - each selected edge steps count by one
// - count match sets sticky capture-match flags
// - down match reloads, disables; up reloads zero
// - adc trigger and dma request on events
// - capture bit set selects edge time mode
// - edge copies count into snapshot, sets event
// - edge time keeps running, reloads at timeout
// - free running count always readable separately
// - pwm decode: alternate 1, capture 0, mode 1/2; capture bit not decoded
// - pwm counts down, reloads, may await trigger
// - pwm output edges set event flags if enabled
// - pwm asserts at start, drops at match, invertible
// - debug stall freezes counting outside clock mode
// - match update deferred to timeout when selected
package timer_pkg;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MODE = 12'h004;
  localparam logic [11:0] REG_MASK = 12'h008;
  localparam logic [11:0] REG_RAW = 12'h00c;
  localparam logic [11:0] REG_MIS = 12'h010;
  localparam logic [11:0] REG_CLEAR = 12'h014;
  localparam logic [11:0] REG_ILOAD = 12'h018;
  localparam logic [11:0] REG_PLOAD = 12'h01c;
  localparam logic [11:0] REG_MATCH = 12'h020;
  localparam logic [11:0] REG_PMATCH = 12'h024;
  localparam logic [11:0] REG_CAPT = 12'h028;
  localparam logic [11:0] REG_PSNAP = 12'h02c;
  localparam logic [11:0] REG_VALUE = 12'h030;
  localparam logic [11:0] REG_PVALUE = 12'h034;
  localparam logic [11:0] REG_PREDIV = 12'h038;
  // control register fields
  localparam int CTL_W = 7;
  localparam int CTL_EN = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_EVT = 2;
  localparam int CTL_CLOCK_MODE_ENABLE = 4;
  localparam int CTL_OTE = 5;
  localparam int CTL_PWML = 6;
  // mode register fields
  localparam int MR_W = 10;
  localparam int MR_TMR = 0;
  localparam int MR_CMR = 2;
  localparam int MR_AMS = 3;
  localparam int MR_UP = 4;
  localparam int MR_WOT = 5;
  localparam int MR_PWMIE = 6;
  localparam int MR_MATCH_UPDATE_AT_TIMEOUT = 7;
  localparam int MR_PLO = 8;
  localparam int MR_RTC = 9;
  localparam logic [1:0] TMR_ONE = 2'h1;
  localparam logic [1:0] TMR_PER = 2'h2;
  localparam logic [1:0] TMR_CAP = 2'h3;
  // edge event field codes
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  // interrupt flag positions
  localparam int IRQ_W = 3;
  localparam int IRQ_CM = 0;
  localparam int IRQ_CE = 1;
  localparam int IRQ_RTC = 2;
  // reset and load values
  localparam logic [31:0] ILOAD_RST = 32'hffffffff;
  localparam logic [31:0] CNT_RST = 32'hffffffff;
  localparam logic [31:0] RTC_FIRST = 32'h00000001;
  // clock-mode divider
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int PREDIV_W = 15;
  localparam logic [PREDIV_W-1:0] PREDIV_TOP = PREDIV_W'(RTC_IN_HZ / RTC_TICK_HZ - 1);
  // decoded operating mode, gray along off-count-time-pwm-rtc
  typedef enum logic [2:0]
  {
    M_OFF = 3'h0,
    M_COUNT = 3'h1,
    M_TIME = 3'h3,
    M_PWM = 3'h2,
    M_RTC = 3'h6
  } mode_t;
endpackage : timer_pkg

// File: logic/ccp_edge_detect.sv
// pin synchroniser with rising and falling edge pulses
// assumes the pin level may change at any time relative to pclk
`timescale 1ns/1ps
module ccp_edge_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic last;

  // two stages, then a third for comparison only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  // compare settled samples only, never the first stage
  assign rise = sync & ~last;
  assign fall = ~sync & last;
endmodule : ccp_edge_detect

// File: logic/timer_capture_pwm.sv
// one timer channel: clock, edge count, edge time and pwm modes
// assumes an apb3 master on pclk and an asynchronous ccp input
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module timer_capture_pwm #(
  parameter int TW = 16,
  parameter int PW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture/compare pin
  input wire logic ccp_in,
  output logic ccp_out,
  output logic ccp_out_en,
  // system
  input wire logic debug_halt,
  input wire logic chain_trigger,
  output logic adc_trigger,
  output logic dma_request,
  output logic irq
);
  localparam int MW = TW + PW;

  localparam int CTL_W_L = timer_pkg::CTL_W;
  logic [CTL_W_L-1:0] ctl;
  logic [timer_pkg::MR_W-1:0] mr;
  logic [timer_pkg::IRQ_W-1:0] imask;
  logic [timer_pkg::IRQ_W-1:0] raw;
  logic [31:0] ilr;
  logic [PW-1:0] pload;
  logic [31:0] match_reg;
  logic [PW-1:0] pmatch_reg;
  logic [31:0] match_act;
  logic [PW-1:0] pmatch_act;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [TW-1:0] capt;
  logic [PW-1:0] psnap;
  logic [timer_pkg::PREDIV_W-1:0] prediv;
  logic rtc_seen;
  logic en_q;
  logic wot_wait;
  logic pwm_lvl;
  logic next_lvl;
  logic set_cm;
  logic timeout;
  logic hw_dis;

  // apb handshake: one wait state, effect at the pready edge
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd_mux;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // write strobes per register
  logic wr_ctl;
  logic wr_mr;
  logic wr_mask;
  logic wr_clr;
  logic wr_ilr;
  logic wr_pld;
  logic wr_mt;
  logic wr_pmt;
  assign wr_ctl = wr & (paddr == timer_pkg::REG_CTRL);
  assign wr_mr = wr & (paddr == timer_pkg::REG_MODE);
  assign wr_mask = wr & (paddr == timer_pkg::REG_MASK);
  assign wr_clr = wr & (paddr == timer_pkg::REG_CLEAR);
  assign wr_ilr = wr & (paddr == timer_pkg::REG_ILOAD);
  assign wr_pld = wr & (paddr == timer_pkg::REG_PLOAD);
  assign wr_mt = wr & (paddr == timer_pkg::REG_MATCH);
  assign wr_pmt = wr & (paddr == timer_pkg::REG_PMATCH);

  // pin edges
  logic rise;
  logic fall;
  ccp_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ccp_in),
    .rise(rise),
    .fall(fall)
  );

  // mode decode
  timer_pkg::mode_t mode;
  logic [1:0] tmr;
  logic up;
  assign tmr = mr[timer_pkg::MR_TMR +: 2];
  assign up = mr[timer_pkg::MR_UP];
  assign mode = mr[timer_pkg::MR_RTC] ? timer_pkg::M_RTC :
                (tmr == timer_pkg::TMR_CAP && mr[timer_pkg::MR_CMR]) ? timer_pkg::M_TIME :
                (tmr == timer_pkg::TMR_CAP) ? timer_pkg::M_COUNT :
                (mr[timer_pkg::MR_AMS] && (tmr == timer_pkg::TMR_ONE || tmr == timer_pkg::TMR_PER))
                  ? timer_pkg::M_PWM : timer_pkg::M_OFF;

  // run qualification; clock mode is exempt from the debug freeze
  logic en;
  logic en_rise;
  logic stall;
  logic run;
  logic is_rtc;
  assign en = ctl[timer_pkg::CTL_EN];
  assign en_rise = en & ~en_q;
  assign is_rtc = (mode == timer_pkg::M_RTC);
  assign stall = debug_halt & ctl[timer_pkg::CTL_STALL]
                 & ~(is_rtc & ctl[timer_pkg::CTL_CLOCK_MODE_ENABLE]);
  assign run = en & ~stall & ~wot_wait;

  // selected input edge
  logic [1:0] evt;
  logic sel_edge;
  assign evt = ctl[timer_pkg::CTL_EVT +: 2];
  assign sel_edge = (rise & (evt != timer_pkg::EVT_FALL)) | (fall & (evt != timer_pkg::EVT_RISE));

  // combined prescale-high, timer-low values
  logic [MW-1:0] mcnt;
  logic [MW-1:0] load_m;
  logic [MW-1:0] match_m;
  logic [MW-1:0] start_m;
  logic [MW-1:0] step_m;
  assign mcnt = cnt[MW-1:0];
  assign load_m = {pload, ilr[TW-1:0]};
  assign match_m = {pmatch_act, match_act[TW-1:0]};
  assign start_m = up ? {MW{1'b0}} : load_m;
  assign step_m = up ? mcnt + MW'(1) : mcnt - MW'(1);

  // clock-mode predivider tick
  logic tick;
  assign tick = rise & (prediv == timer_pkg::PREDIV_TOP);

  // counter next value per mode
  always_comb
  begin
    next_cnt = cnt;
    set_cm = 1'b0;
    timeout = 1'b0;
    hw_dis = 1'b0;
    unique case (mode)
      timer_pkg::M_RTC:
      begin
        if (!rtc_seen)
          next_cnt = timer_pkg::RTC_FIRST;
        else if (wr_ilr)
          next_cnt = pwdata;
        else if (run && tick)
        begin
          next_cnt = cnt + 32'h00000001;
          timeout = (cnt == 32'hffffffff);
        end
      end
      timer_pkg::M_COUNT:
      begin
        if (en_rise)
          next_cnt = {{(32-MW){1'b0}}, start_m};
        else if (run && sel_edge)
        begin
          if (step_m == match_m)
          begin
            set_cm = 1'b1;
            timeout = 1'b1;
            hw_dis = ~up;
            next_cnt = {{(32-MW){1'b0}}, start_m};
          end
          else
            next_cnt = {{(32-MW){1'b0}}, step_m};
        end
      end
      timer_pkg::M_TIME:
      begin
        if (en_rise)
          next_cnt = {{(32-MW){1'b0}}, start_m};
        else if (run)
        begin
          if (mcnt == (up ? load_m : {MW{1'b0}}))
          begin
            timeout = 1'b1;
            next_cnt = {{(32-MW){1'b0}}, start_m};
          end
          else
            next_cnt = {{(32-MW){1'b0}}, step_m};
        end
      end
      timer_pkg::M_PWM:
      begin
        if (en_rise)
          next_cnt = {{(32-MW){1'b0}}, load_m};
        else if (run)
        begin
          if (mcnt == {MW{1'b0}})
          begin
            timeout = 1'b1;
            next_cnt = {{(32-MW){1'b0}}, load_m};
          end
          else
            next_cnt = {{(32-MW){1'b0}}, mcnt - MW'(1)};
        end
      end
      default:
        next_cnt = cnt;
    endcase
  end

  // pwm level: set at start value, dropped at match
  logic next_out;
  logic pwm_evt;
  assign next_lvl = (next_cnt[MW-1:0] == load_m) ? 1'b1 :
                    (next_cnt[MW-1:0] == match_m) ? 1'b0 : pwm_lvl;
  assign next_out = (mode == timer_pkg::M_PWM && en) ? (next_lvl ^ ctl[timer_pkg::CTL_PWML]) : 1'b0;
  assign pwm_evt = (mode == timer_pkg::M_PWM)
                   & ((next_out & ~ccp_out & (evt != timer_pkg::EVT_FALL))
                   | (~next_out & ccp_out & (evt != timer_pkg::EVT_RISE)));

  // event sources feeding the sticky flags
  logic cap_evt;
  logic set_ce;
  logic set_rtc;
  logic [timer_pkg::IRQ_W-1:0] set_raw;
  logic [timer_pkg::IRQ_W-1:0] next_raw;
  assign cap_evt = (mode == timer_pkg::M_TIME) & run & sel_edge;
  assign set_ce = cap_evt | (pwm_evt & mr[timer_pkg::MR_PWMIE]);
  assign set_rtc = is_rtc & rtc_seen & run & tick & ~wr_ilr & ((cnt + 32'h00000001) == match_act);
  assign set_raw = {set_rtc, set_ce, set_cm};
  assign next_raw = (raw & ~(wr_clr ? pwdata[timer_pkg::IRQ_W-1:0] : {timer_pkg::IRQ_W{1'b0}}))
                    | set_raw;

  // control and mode registers; hardware disable after down match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl <= '0;
      mr <= '0;
      imask <= '0;
    end
    else
    begin
      if (wr_ctl)
        ctl <= pwdata[CTL_W_L-1:0];
      else if (hw_dis)
        ctl[timer_pkg::CTL_EN] <= 1'b0;
      if (wr_mr)
        mr <= pwdata[timer_pkg::MR_W-1:0];
      if (wr_mask)
        imask <= pwdata[timer_pkg::IRQ_W-1:0];
    end
  end

  // load and match registers, with active copies of the match pair
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ilr <= timer_pkg::ILOAD_RST;
      pload <= '0;
      match_reg <= timer_pkg::ILOAD_RST;
      pmatch_reg <= '0;
      match_act <= timer_pkg::ILOAD_RST;
      pmatch_act <= '0;
    end
    else
    begin
      if (wr_ilr)
        ilr <= pwdata;
      if (wr_pld)
        pload <= pwdata[PW-1:0];
      if (wr_mt)
        match_reg <= pwdata;
      if (wr_pmt)
        pmatch_reg <= pwdata[PW-1:0];
      // deferred copy avoids a mid-period duty change
      if (!mr[timer_pkg::MR_MATCH_UPDATE_AT_TIMEOUT] || timeout)
      begin
        match_act <= match_reg;
        pmatch_act <= pmatch_reg;
      end
    end
  end

  // counter, snapshot, predivider and start bookkeeping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= timer_pkg::CNT_RST;
      capt <= '0;
      psnap <= '0;
      prediv <= '0;
      rtc_seen <= 1'b0;
      en_q <= 1'b0;
      wot_wait <= 1'b0;
      pwm_lvl <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      en_q <= en;
      pwm_lvl <= next_lvl;
      if (is_rtc)
        rtc_seen <= 1'b1;
      if (is_rtc && en && !stall && rise)
        prediv <= prediv + timer_pkg::PREDIV_W'(1);
      if (cap_evt)
      begin
        capt <= mcnt[TW-1:0];
        psnap <= mcnt[MW-1:TW];
      end
      // a trigger arriving with the enable still starts the count
      if (en_rise && mode == timer_pkg::M_PWM && mr[timer_pkg::MR_WOT] && !chain_trigger)
        wot_wait <= 1'b1;
      else if (chain_trigger || !en)
        wot_wait <= 1'b0;
    end
  end

  // flags and registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw <= '0;
      irq <= 1'b0;
      ccp_out <= 1'b0;
      ccp_out_en <= 1'b0;
      adc_trigger <= 1'b0;
      dma_request <= 1'b0;
    end
    else
    begin
      raw <= next_raw;
      irq <= |(next_raw & imask);
      ccp_out <= next_out;
      ccp_out_en <= (mode == timer_pkg::M_PWM);
      adc_trigger <= ctl[timer_pkg::CTL_OTE] & (set_cm | cap_evt | pwm_evt);
      dma_request <= |set_raw;
    end
  end

  // read decode; free-running values stay apart from snapshots
  always_comb
  begin
    mapped = 1'b1;
    unique case (paddr)
      timer_pkg::REG_CTRL: rd_mux = {{(32-CTL_W_L){1'b0}}, ctl};
      timer_pkg::REG_MODE: rd_mux = {{(32-timer_pkg::MR_W){1'b0}}, mr};
      timer_pkg::REG_MASK: rd_mux = {{(32-timer_pkg::IRQ_W){1'b0}}, imask};
      timer_pkg::REG_RAW: rd_mux = {{(32-timer_pkg::IRQ_W){1'b0}}, raw};
      timer_pkg::REG_MIS: rd_mux = {{(32-timer_pkg::IRQ_W){1'b0}}, raw & imask};
      timer_pkg::REG_CLEAR: rd_mux = 32'h00000000;
      timer_pkg::REG_ILOAD: rd_mux = ilr;
      timer_pkg::REG_PLOAD: rd_mux = {{(32-PW){1'b0}}, pload};
      timer_pkg::REG_MATCH: rd_mux = match_reg;
      timer_pkg::REG_PMATCH: rd_mux = {{(32-PW){1'b0}}, pmatch_reg};
      timer_pkg::REG_CAPT: rd_mux = {{(32-TW){1'b0}}, capt};
      timer_pkg::REG_PSNAP: rd_mux = {{(32-PW){1'b0}}, psnap};
      timer_pkg::REG_VALUE: rd_mux = is_rtc ? cnt : {{(32-TW){1'b0}}, mcnt[TW-1:0]};
      timer_pkg::REG_PVALUE: rd_mux = {{(32-PW){1'b0}}, mcnt[MW-1:TW]};
      timer_pkg::REG_PREDIV: rd_mux = {{(32-timer_pkg::PREDIV_W){1'b0}}, prediv};
      default:
      begin
        rd_mux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end
endmodule : timer_capture_pwm

// File: verification/timer_capture_pwm_monitor.sv
// port assertions for one timer channel
// assumes the single pclk domain with async presetn
`timescale 1ns/1ps
module timer_capture_pwm_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and system
  input wire logic ccp_in,
  input wire logic ccp_out,
  input wire logic ccp_out_en,
  input wire logic adc_trigger,
  input wire logic dma_request,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed writes that may move the interrupt line
  wire acc = psel && penable && pready && pwrite;
  wire clr_all = acc && paddr == timer_pkg::REG_CLEAR && pwdata[2:0] == 3'h7;
  wire irq_wr = acc && (paddr == timer_pkg::REG_CLEAR || paddr == timer_pkg::REG_MASK);
  // exactly one wait state per transfer
  property p_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer timing wrong");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_out_en;
    !ccp_out_en |-> !ccp_out;
  endproperty
  a_out_en: assert property (p_out_en) else $error("pwm output outside pwm");
  // a hardware set in the same cycle wins over the clear
  property p_clear;
    clr_all |=> !irq || dma_request;
  endproperty
  a_clear: assert property (p_clear) else $error("irq survived clear");
  property p_irq_rise;
    $rose(irq) |-> dma_request || $past(dma_request) || $past(irq_wr) || $past(irq_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_hold;
    $fell(irq) |-> $past(irq_wr) || $past(irq_wr, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped by itself");
  property p_adc;
    adc_trigger |=> !adc_trigger;
  endproperty
  a_adc: assert property (p_adc) else $error("adc trigger not a pulse");
  // pin events land three to four edges after the pin moved
  property p_lat;
    adc_trigger && !ccp_out_en |-> $past(ccp_in, 3) != $past(ccp_in, 4) || $past(ccp_in, 4) != $past(ccp_in, 5);
  endproperty
  a_lat: assert property (p_lat) else $error("pin event latency wrong");
endmodule : timer_capture_pwm_monitor

bind timer_capture_pwm timer_capture_pwm_monitor u_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .ccp_in, .ccp_out, .ccp_out_en,
  .adc_trigger, .dma_request, .irq);

// File: verification/ccp_pin_model.sv
// outside signal source on the capture/compare pin
// assumes burst is called just after a rising pclk edge
`timescale 1ns/1ps
module ccp_pin_model (
  // clock
  input wire logic pclk,
  // pin
  output logic pin
);
  initial pin = 1'b0;
  // toggle n times; the pin rests at its level between bursts
  task automatic burst(input int n, input int h);
    int hh;
    begin
      hh = (h < 2) ? 2 : h;
      repeat (n)
      begin
        pin <= ~pin;
        repeat (hh) @(posedge pclk);
      end
    end
  endtask : burst
endmodule : ccp_pin_model

// File: verification/tb_timer_rtc_capture_pwm_modes.sv
// self-checking bench for the timer channel
// assumes the monitor bind and the pin model are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_timer_rtc_capture_pwm_modes;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic debug_halt = 1'b0;
  logic chain_trigger = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ccp_in, ccp_out, ccp_out_en, adc_trigger, dma_request, irq;
  logic [33:0] expq[$];
  logic [33:0] note;
  logic [31:0] rv, c;
  logic [31:0] seed = 32'h0001819f;
  logic [31:0] ctl[3] = '{32'h2c, 32'h2d, 32'h2f};
  int dcnt[3] = '{1, 3, 0};
  int checks = 0;
  int mismatches = 0;
  int dmas = 0;
  int adcs = 0;
  int d0, a0, a, b, h, lv, mv;

  timer_capture_pwm #(.TW(16), .PW(8)) u_timer_capture_pwm (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ccp_in(ccp_in), .ccp_out(ccp_out),
    .ccp_out_en(ccp_out_en), .debug_halt(debug_halt), .chain_trigger(chain_trigger),
    .adc_trigger(adc_trigger), .dma_request(dma_request), .irq(irq));
  ccp_pin_model u_ccp_pin_model (.pclk(pclk), .pin(ccp_in));

  always #2.5 pclk = ~pclk;

  // oldest note against each read answer
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      note = expq.pop_front();
      if (!note[33])
        `CHK({pslverr, prdata}, note[32:0])
    end
  end

  // count dma pulses, one per hardware flag set
  always @(posedge pclk)
    if (dma_request === 1'b1)
      dmas <= dmas + 1;

  // count adc pulses, one per count match, capture or pwm event with trigger enable
  always @(posedge pclk)
    if (adc_trigger === 1'b1)
      adcs <= adcs + 1;

  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask : close_out

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
    end
  endfunction : xs

  // one apb transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [33:0] x);
    int n;
    begin
      if (!w)
        expq.push_back(x);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
        mismatches++;
        close_out();
      end
      @(posedge pclk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 34'h0);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    apb(1'b0, ad, 32'h0, {1'b0, e});
  endtask : rd

  task automatic rdx(input logic [11:0] ad);
    apb(1'b0, ad, 32'h0, {1'b1, 33'h0});
  endtask : rdx

  // cycles until the pwm pin shows level v
  task automatic wl(input logic v, output int n);
    begin
      n = 0;
      while (ccp_out !== v && n < 200)
      begin
        @(posedge pclk);
        n++;
      end
      if (n >= 200)
      begin
        mismatches++;
        close_out();
      end
    end
  endtask : wl

  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chain_trigger <= 1'b1;
    rd(12'h100, 33'h100000000);
    // edge count: down, up, then stalled by the debugger
    for (int i = 0; i < 3; i++)
    begin
      wr(timer_pkg::REG_CTRL, 32'h0);
      wr(timer_pkg::REG_CLEAR, 32'h7);
      wr(timer_pkg::REG_MODE, i == 1 ? 32'h13 : 32'h3);
      wr(timer_pkg::REG_ILOAD, 32'ha);
      wr(timer_pkg::REG_MATCH, i == 1 ? 32'h2 : 32'h6);
      wr(timer_pkg::REG_MASK, 32'h1);
      d0 = dmas;
      wr(timer_pkg::REG_CTRL, i == 2 ? 32'h2f : 32'h2d);
      debug_halt <= (i == 2);
      seed = xs(seed);
      u_ccp_pin_model.burst(6, 2 + int'(seed[1:0]));
      repeat (6) @(posedge pclk);
      `CHK(dmas - d0, dcnt[i])
      rd(timer_pkg::REG_RAW, i == 2 ? 33'h0 : 33'h1);
      rd(timer_pkg::REG_MIS, i == 2 ? 33'h0 : 33'h1);
      rd(timer_pkg::REG_CTRL, {1'b0, ctl[i]});
      rd(timer_pkg::REG_VALUE, i == 1 ? 33'h0 : 33'ha);
      rd(timer_pkg::REG_PVALUE, 33'h0);
      `CHK(irq, i != 2)
      debug_halt <= 1'b0;
    end
    // edge time over every edge selection
    wr(timer_pkg::REG_ILOAD, 32'hffff); // long period, no wrap between capture and value read
    for (int ev = 0; ev < 4; ev++)
    begin
      wr(timer_pkg::REG_CTRL, 32'h0);
      wr(timer_pkg::REG_CLEAR, 32'h7);
      wr(timer_pkg::REG_MODE, 32'h17);
      wr(timer_pkg::REG_MASK, 32'h2);
      d0 = dmas;
      a0 = adcs;
      wr(timer_pkg::REG_CTRL, 32'h21 | 32'(ev << 2));
      u_ccp_pin_model.burst(2, 3);
      repeat (6) @(posedge pclk);
      `CHK(dmas - d0, ev < 2 ? 1 : 2)
      `CHK(adcs - a0, ev < 2 ? 1 : 2)
      rd(timer_pkg::REG_RAW, 33'h2);
      `CHK(irq, 1'b1)
      rdx(timer_pkg::REG_CAPT);
      c = rv;
      rdx(timer_pkg::REG_VALUE);
      `CHK(rv > c, 1'b1)
      rd(timer_pkg::REG_CAPT, {1'b0, c});
    end
    // pwm, plain then inverted, random period and match
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      lv = 16 + int'(seed[3:0]);
      seed = xs(seed);
      mv = 2 + int'(seed % 32'(lv - 4));
      wr(timer_pkg::REG_CTRL, 32'h0);
      wr(timer_pkg::REG_CLEAR, 32'h7);
      // mode off first so the new match is live before deferred updates start
      wr(timer_pkg::REG_MODE, 32'h0);
      wr(timer_pkg::REG_ILOAD, 32'(lv));
      wr(timer_pkg::REG_MATCH, 32'(mv));
      wr(timer_pkg::REG_MODE, 32'h1ea);
      chain_trigger <= 1'b0;
      wr(timer_pkg::REG_CTRL, 32'h2d | 32'(k << 6));
      rd(timer_pkg::REG_VALUE, {1'b0, 32'(lv)});
      chain_trigger <= 1'b1;
      // first segment may include the trigger wait, so measure later ones
      wl(1'b1, a);
      wl(1'b0, a);
      wl(1'b1, b);
      wl(1'b0, h);
      `CHK(b + h, lv + 1)
      `CHK(h, k ? mv + 1 : lv - mv)
      `CHK(ccp_out_en, 1'b1)
      rd(timer_pkg::REG_RAW, 33'h2);
    end
    // clock mode: first load, predivider through a debugger halt
    wr(timer_pkg::REG_CTRL, 32'h0);
    wr(timer_pkg::REG_CLEAR, 32'h7);
    wr(timer_pkg::REG_MODE, 32'h200);
    rd(timer_pkg::REG_VALUE, 33'h1);
    wr(timer_pkg::REG_MATCH, 32'h3);
    wr(timer_pkg::REG_CTRL, 32'h13);
    debug_halt <= 1'b1;
    u_ccp_pin_model.burst(40, 2);
    repeat (6) @(posedge pclk);
    rd(timer_pkg::REG_PREDIV, 33'h14);
    debug_halt <= 1'b0;
    rd(timer_pkg::REG_VALUE, 33'h1);
    wr(timer_pkg::REG_ILOAD, 32'h5);
    rd(timer_pkg::REG_VALUE, 33'h5);
    rd(timer_pkg::REG_RAW, 33'h0);
    close_out();
  end
endmodule : tb_timer_rtc_capture_pwm_modes
